// ==== design/fdx_map.svh ====
`ifndef FDX_MAP_SVH
`define FDX_MAP_SVH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define FDX_IDX_RX_BYTE    8'h28
`define FDX_IDX_MATCH_A    8'h29
`define FDX_IDX_MATCH_B    8'h2A
`define FDX_IDX_TX_BYTE    8'h7E
`define FDX_IDX_CTRL       8'h30
`define FDX_IDX_STATUS     8'h31
`define FDX_IDX_MASK       8'h32

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define FDX_CTL_DESTUFF    0
`define FDX_CTL_FRAME      3
`define FDX_CTL_STUFF      4

// ----------------------------------------------------------------
// status and mask fields
// ----------------------------------------------------------------
`define FDX_ST_MATCH       2
`define FDX_ST_TX_EMPTY    3
`define FDX_ST_RX_FULL     4
`define FDX_ST_USED        8'h1C

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define FDX_RST_BYTE       8'h00
`define FDX_BITS_PER_BYTE  4'h8
`define FDX_ONES_STUFF     3'h5
`define FDX_ONES_SAT       3'h6

`endif

// ==== design/fdx_pkg.sv ====
package fdx_pkg;

  // ----------------------------------------------------------------
  // framing mode
  // ----------------------------------------------------------------
  typedef enum logic {
    FDX_D4,
    FDX_ESF
  } fdx_frame_t;

  // ----------------------------------------------------------------
  // receive bit stream from the framer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic bit_val;
    logic fdl_slot;
    logic fs_slot;
  } fdx_rx_link_t;

  // ----------------------------------------------------------------
  // transmit slot strobes from the framer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic fdl_slot;
    logic fs_slot;
  } fdx_tx_slot_t;

endpackage

// ==== design/fdx_top.sv ====
`timescale 1ns/100ps
`include "fdx_map.svh"

module fdx_top
  import fdx_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         cyc_i,
  input  wire logic         stb_i,
  input  wire logic         we_i,
  input  wire logic [9:0]   adr_i,
  input  wire logic [3:0]   sel_i,
  input  wire logic [31:0]  dat_i,
  output logic      [31:0]  dat_o,
  output logic              ack_o,
  input  wire fdx_rx_link_t rx_link_i,
  input  wire fdx_tx_slot_t tx_slot_i,
  output logic              tx_link_bit_o,
  output logic              second_irq_n_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] rx_link_byte_r;
  logic [7:0] rx_link_match_a_r;
  logic [7:0] rx_link_match_b_r;
  logic [7:0] tx_link_byte_r;
  logic [7:0] ctrl_r;
  logic [7:0] status_r;
  logic [7:0] mask_r;
  logic [7:0] rd_nxt;
  logic [2:0] flag_set;
  logic [2:0] flag_r;
  logic       flag_clr;
  logic       rx_hit;
  logic       irq_any;

  // ----------------------------------------------------------------
  // receive path state
  // ----------------------------------------------------------------
  logic [7:0] rx_sh_r;
  logic [3:0] rx_cnt_r;
  logic [2:0] rx_ones_r;
  logic [7:0] rx_byte_nxt;
  logic       rx_done;
  logic       rx_take;
  logic       rx_drop;

  // ----------------------------------------------------------------
  // transmit path state
  // ----------------------------------------------------------------
  logic [7:0] tx_sh_r;
  logic [3:0] tx_cnt_r;
  logic [2:0] tx_ones_r;
  logic       tx_stuff;
  logic       tx_bit_nxt;
  logic       tx_take;
  logic       tx_done;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic       wb_req;
  logic       wb_wr;
  logic [7:0] idx;
  fdx_frame_t frame_mode;

  assign wb_req     = cyc_i & stb_i & ~ack_o;
  assign wb_wr      = wb_req & we_i & sel_i[0];
  assign idx        = adr_i[9:2];
  assign frame_mode = fdx_frame_t'(ctrl_r[`FDX_CTL_FRAME]);

  // ----------------------------------------------------------------
  // slot selection
  // ----------------------------------------------------------------
  // mode picks slot
  assign rx_take = (frame_mode == FDX_ESF) ? rx_link_i.fdl_slot
                                           : rx_link_i.fs_slot;
  assign tx_take = (frame_mode == FDX_ESF) ? tx_slot_i.fdl_slot
                                           : tx_slot_i.fs_slot;

  // ----------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------
  // drop zero after exactly five ones
  assign rx_drop = ctrl_r[`FDX_CTL_DESTUFF] & ~rx_link_i.bit_val
                   & (rx_ones_r == `FDX_ONES_STUFF);
  // shift in from the top, lsb first
  assign rx_byte_nxt = {rx_link_i.bit_val, rx_sh_r[7:1]};
  assign rx_done     = rx_take & ~rx_drop
                       & (rx_cnt_r == (`FDX_BITS_PER_BYTE - 4'h1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_ones_r <= 3'h0;
    end else if (rx_take) begin
      if (!rx_link_i.bit_val) begin
        rx_ones_r <= 3'h0;
      end else if (rx_ones_r != `FDX_ONES_SAT) begin
        rx_ones_r <= rx_ones_r + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_sh_r <= `FDX_RST_BYTE;
    end else if (rx_take && !rx_drop) begin
      rx_sh_r <= rx_byte_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_cnt_r <= 4'h0;
    end else if (rx_take && !rx_drop) begin
      rx_cnt_r <= rx_done ? 4'h0 : rx_cnt_r + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // receive byte register
  // ----------------------------------------------------------------
  // unread byte is overwritten
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_link_byte_r <= `FDX_RST_BYTE;
    end else if (rx_done) begin
      rx_link_byte_r <= rx_byte_nxt;
    end
  end

  // ----------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------
  // zero after five ones
  assign tx_stuff   = ctrl_r[`FDX_CTL_STUFF] & (tx_ones_r == `FDX_ONES_STUFF);
  assign tx_bit_nxt = tx_stuff ? 1'b0 : tx_sh_r[0];
  assign tx_done    = tx_take & ~tx_stuff
                      & (tx_cnt_r == (`FDX_BITS_PER_BYTE - 4'h1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_cnt_r <= 4'h0;
    end else if (tx_take && !tx_stuff) begin
      tx_cnt_r <= tx_done ? 4'h0 : tx_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_sh_r <= `FDX_RST_BYTE;
    end else if (tx_done) begin
      tx_sh_r <= tx_link_byte_r;
    end else if (tx_take && !tx_stuff) begin
      tx_sh_r <= {1'b0, tx_sh_r[7:1]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_ones_r <= 3'h0;
    end else if (tx_take) begin
      if (!tx_bit_nxt) begin
        tx_ones_r <= 3'h0;
      end else begin
        tx_ones_r <= tx_ones_r + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit output
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_link_bit_o <= 1'b0;
    end else begin
      tx_link_bit_o <= tx_bit_nxt;
    end
  end

  // ----------------------------------------------------------------
  // status flags and interrupt
  // ----------------------------------------------------------------
  // match either
  assign rx_hit   = (rx_byte_nxt == rx_link_match_a_r)
                    | (rx_byte_nxt == rx_link_match_b_r);
  assign flag_set = {rx_done, tx_done, rx_done & rx_hit};
  assign flag_clr = wb_wr & (idx == `FDX_IDX_STATUS);

  // set wins over a clear in the same cycle
  for (genvar g = 0; g < 3; g++) begin : g_flag
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        flag_r[g] <= 1'b0;
      end else if (flag_set[g]) begin
        flag_r[g] <= 1'b1;
      end else if (flag_clr && dat_i[g + `FDX_ST_MATCH]) begin
        flag_r[g] <= 1'b0;
      end
    end
  end

  assign status_r = {3'h0, flag_r, 2'h0};

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  assign irq_any = |(status_r & mask_r);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      second_irq_n_o <= 1'b1;
    end else begin
      second_irq_n_o <= ~irq_any;
    end
  end

  // ----------------------------------------------------------------
  // host writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_link_match_a_r <= `FDX_RST_BYTE;
    end else if (wb_wr && idx == `FDX_IDX_MATCH_A) begin
      rx_link_match_a_r <= dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_link_match_b_r <= `FDX_RST_BYTE;
    end else if (wb_wr && idx == `FDX_IDX_MATCH_B) begin
      rx_link_match_b_r <= dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_link_byte_r <= `FDX_RST_BYTE;
    end else if (wb_wr && idx == `FDX_IDX_TX_BYTE) begin
      tx_link_byte_r <= dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= 8'h00;
    end else if (wb_wr && idx == `FDX_IDX_CTRL) begin
      ctrl_r <= dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= 8'h00;
    end else if (wb_wr && idx == `FDX_IDX_MASK) begin
      mask_r <= dat_i[7:0] & `FDX_ST_USED;
    end
  end

  // ----------------------------------------------------------------
  // wishbone read and ack
  // ----------------------------------------------------------------
  always_comb begin
    if (idx == `FDX_IDX_RX_BYTE) begin
      rd_nxt = rx_link_byte_r;
    end else if (idx == `FDX_IDX_MATCH_A) begin
      rd_nxt = rx_link_match_a_r;
    end else if (idx == `FDX_IDX_MATCH_B) begin
      rd_nxt = rx_link_match_b_r;
    end else if (idx == `FDX_IDX_TX_BYTE) begin
      rd_nxt = tx_link_byte_r;
    end else if (idx == `FDX_IDX_CTRL) begin
      rd_nxt = ctrl_r;
    end else if (idx == `FDX_IDX_STATUS) begin
      rd_nxt = status_r;
    end else if (idx == `FDX_IDX_MASK) begin
      rd_nxt = mask_r;
    end else begin
      rd_nxt = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= wb_req;
    end
  end

  // read data holds until the next read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (wb_req && !we_i) begin
      dat_o <= {24'h00_0000, rd_nxt};
    end
  end

endmodule

// ==== testbench/fdx_top_sva.sv ====
`timescale 1ns/100ps
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module fdx_top_chk
  import fdx_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         rst_i,
  input wire logic         cyc_i,
  input wire logic         stb_i,
  input wire logic         we_i,
  input wire logic [9:0]   adr_i,
  input wire logic [3:0]   sel_i,
  input wire logic [31:0]  dat_i,
  input wire logic [31:0]  dat_o,
  input wire logic         ack_o,
  input wire fdx_rx_link_t rx_link_i,
  input wire fdx_tx_slot_t tx_slot_i,
  input wire logic         tx_link_bit_o,
  input wire logic         second_irq_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_reset_outputs: assert property ($fell(rst_i) |-> !ack_o && dat_o == 32'h0
    && second_irq_n_o) else $error("outputs not at reset values");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_ack_answers: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  a_read_upper: assert property (dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_read_holds: assert property (!ack_o |-> $stable(dat_o))
    else $error("read data moved without ack");
  a_tx_bit_moves: assert property ($changed(tx_link_bit_o) |->
    $past(tx_slot_i.fdl_slot | tx_slot_i.fs_slot, 2)) else $error("tx bit moved off slot");
  a_irq_rise_cause: assert property ($rose(second_irq_n_o) |-> $past(ack_o && we_i))
    else $error("interrupt released without host write");
  a_irq_fall_cause: assert property ($fell(second_irq_n_o) |-> $past(ack_o && we_i) ||
    $past(rx_link_i.fdl_slot | rx_link_i.fs_slot | tx_slot_i.fdl_slot | tx_slot_i.fs_slot, 2))
    else $error("interrupt raised without cause");
endmodule

bind fdx_top fdx_top_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .rx_link_i(rx_link_i), .tx_slot_i(tx_slot_i), .tx_link_bit_o(tx_link_bit_o),
  .second_irq_n_o(second_irq_n_o));

// ==== testbench/fdx_framer_model.sv ====
`timescale 1ns/100ps
// ----------------------------------------------------------------
// framer stand-in: one slot pair every four cycles
// ----------------------------------------------------------------
module fdx_framer_model
  import fdx_pkg::*;
(
  input  wire logic    clk_i,
  input  wire logic    rst_i,
  input  wire logic    esf_i,
  input  wire logic    tx_bit_i,
  output fdx_rx_link_t rx_o,
  output fdx_tx_slot_t tx_o
);
  logic [1:0] cnt_r;
  logic       rxq[$];
  logic       txq[$];
  initial {rx_o, tx_o, cnt_r} = 7'h0;
  always @(posedge clk_i) begin
    cnt_r <= rst_i ? 2'h0 : cnt_r + 2'h1;
    rx_o  <= {~rx_o.bit_val & !rst_i, 2'h0};
    tx_o  <= 2'h0;
    if (rst_i) txq.delete();
    // junk pulses on the unselected slot
    if (!rst_i && cnt_r == 2'h1) begin
      tx_o <= {!esf_i, esf_i};
      if (rxq.size() > 0) rx_o <= {~rx_o.bit_val, !esf_i, esf_i};
    end
    // link bits on the selected slot
    if (!rst_i && cnt_r == 2'h3) begin
      tx_o <= {esf_i, !esf_i};
      if (rxq.size() > 0) rx_o <= {rxq.pop_front(), esf_i, !esf_i};
    end
    if (esf_i ? tx_o.fdl_slot : tx_o.fs_slot) txq.push_back(tx_bit_i);
  end
endmodule

// ==== testbench/fdx_top_tb.sv ====
`timescale 1ns/100ps
`include "fdx_map.svh"
module fdx_top_tb
  import fdx_pkg::*;
;
  logic         clk_i, rst_i, cyc_i, stb_i, we_i, esf, tx_bit, irq_n, ack_o;
  logic [9:0]   adr_i;
  logic [31:0]  dat_i, dat_o;
  logic [15:0]  exp_q[$];
  logic         exp_b[$];
  fdx_rx_link_t rx_link;
  fdx_tx_slot_t tx_slot;
  int           error_cnt, samples_checked, ones;
  fdx_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .rx_link_i(rx_link), .tx_slot_i(tx_slot), .tx_link_bit_o(tx_bit), .second_irq_n_o(irq_n));
  fdx_framer_model fr (.clk_i(clk_i), .rst_i(rst_i), .esf_i(esf), .tx_bit_i(tx_bit),
    .rx_o(rx_link), .tx_o(tx_slot));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    input logic [15:0] e, output logic [7:0] r);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {a, 2'h0};
    dat_i <= {24'($urandom), d};
    if (!w) exp_q.push_back(e);
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    r = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, a, d, 16'h0, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] mk);
    logic [7:0] r;
    wb(1'b0, a, 8'h0, {mk, e}, r);
  endtask
  task automatic poll(input int b);
    logic [7:0] r = 8'h0;
    while (!r[b]) wb(1'b0, `FDX_IDX_STATUS, 8'h0, 16'h0, r);
  endtask
  task automatic put(input logic [7:0] v, input logic stf, ref logic q[$]);
    for (int i = 0; i < 8; i++) begin
      q.push_back(v[i]);
      ones = v[i] ? ones + 1 : 0;
      if (stf && ones == 5) begin
        q.push_back(1'b0);
        ones = 0;
      end
    end
  endtask
  // ----------------------------------------------------------------
  // monitors and watchdog
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    logic [15:0] e;
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      e = exp_q.pop_front();
      if (e[15:8] != 8'h0) chk("read", e[7:0], dat_o[7:0] & e[15:8]);
    end
    if (fr.txq.size() > 0 && exp_b.size() > 0)
      chk("tx bit", {7'h0, exp_b.pop_front()}, {7'h0, fr.txq.pop_front()});
  end
  initial begin
    #40000;
    error_cnt++;
    finish_test();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] m, r2, r3, v;
    logic [7:0] ra[8] = '{`FDX_IDX_STATUS, `FDX_IDX_TX_BYTE, `FDX_IDX_CTRL, `FDX_IDX_MASK,
                          `FDX_IDX_MATCH_A, `FDX_IDX_MATCH_B, `FDX_IDX_RX_BYTE, 8'h40};
    {rst_i, cyc_i, stb_i, we_i, esf} = 5'h10;
    adr_i = 10'h0;
    dat_i = 32'h0;
    m = $urandom(32'h2D45);
    m = $urandom;
    r2 = $urandom;
    r3 = 8'($urandom) | 8'h1F;
    foreach (ra[i]) if (i < 4) put(i == 3 ? 8'h1C : {8{i != 0}}, 1'b1, exp_b);
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 4; i++) rd(ra[i], 8'h0, 8'hFF);
    wr(`FDX_IDX_CTRL, 8'h11);
    wr(`FDX_IDX_TX_BYTE, 8'hFF);
    wr(`FDX_IDX_MASK, 8'h08);
    wr(`FDX_IDX_RX_BYTE, r2);
    for (int i = 4; i < 8; i++) rd(ra[i], 8'h0, 8'hFF);
    $display("register test done");
    poll(3);
    chk("irq", 8'h0, {7'h0, irq_n});
    wr(`FDX_IDX_STATUS, 8'h08);
    chk("irq", 8'h1, {7'h0, irq_n});
    poll(3);
    wr(`FDX_IDX_STATUS, 8'h08);
    wr(`FDX_IDX_TX_BYTE, 8'h1C);
    wr(`FDX_IDX_MASK, 8'h14);
    poll(3);
    chk("irq", 8'h1, {7'h0, irq_n});
    wr(`FDX_IDX_STATUS, 8'h08);
    poll(3);
    $display("transmit test done");
    wr(`FDX_IDX_CTRL, 8'h19);
    esf <= 1'b1;
    wr(`FDX_IDX_MATCH_A, m);
    wr(`FDX_IDX_MATCH_B, 8'h7E);
    wr(`FDX_IDX_STATUS, 8'h1C);
    ones = 0;
    for (int i = 0; i < 3; i++) begin
      v = i == 0 ? m : i == 1 ? r3 : 8'h7E;
      put(v, i < 2, fr.rxq);
      poll(4);
      chk("irq", 8'h0, {7'h0, irq_n});
      rd(`FDX_IDX_RX_BYTE, v, 8'hFF);
      rd(`FDX_IDX_STATUS, (v == m || v == 8'h7E) ? 8'h14 : 8'h10, 8'h14);
      wr(`FDX_IDX_STATUS, 8'h1C);
      chk("irq", 8'h1, {7'h0, irq_n});
    end
    $display("receive test done");
    chk("tx left", 8'h0, 8'(exp_b.size()));
    finish_test();
  end
endmodule
